// File: logic/sds_defines.svh
`ifndef SDS_DEFINES_SVH
`define SDS_DEFINES_SVH

// Register indices; byte address is four times the index
`define SDS_IDX_CTRL 12'hc88
`define SDS_IDX_STAT 12'hc89
`define SDS_IDX_DATA0 12'hc8a
`define SDS_IDX_DATA1 12'hc8b
`define SDS_IDX_DATA2 12'hc8c
`define SDS_IDX_DATA3 12'hc8d
`define SDS_IDX_IRQ_ST 12'hc8e
`define SDS_IDX_IRQ_MASK 12'hc8f

// Control field positions
`define SDS_CTRL_MANUAL 0
`define SDS_CTRL_LSB_FIRST 1
`define SDS_CTRL_LEN_LO 2
`define SDS_CTRL_LEN_HI 3
`define SDS_CTRL_MAN_LEVEL 4
`define SDS_CTRL_RESET 5'h00

// Status and interrupt bit positions
`define SDS_STAT_BUSY 0
`define SDS_IRQ_DONE 0
`define SDS_IRQ_REFUSED 1
`define SDS_IRQ_RESET 2'h0

// Timing: serial clock half period, rounded up to whole clock cycles
`define SDS_CLK_NS 50
`define SDS_SCLK_HALF_NS 200
`define SDS_HALF_CYC ((`SDS_SCLK_HALF_NS + `SDS_CLK_NS - 1) / `SDS_CLK_NS)

`endif

// File: logic/sds_pkg.sv
package sds_pkg;

   typedef logic [31:0] sds_word_t;

   // Control register layout, bit 4 down to bit 0
   typedef struct packed {
      logic man_level;
      logic [1:0] frame_length_field;
      logic low_bit_first_order;
      logic manual_select_control;
   } sds_ctrl_s;

   typedef enum logic {
      sds_idle,
      sds_shift
   } sds_state_e;

endpackage

// File: logic/sds_sync.sv
`timescale 1ns/1ps

// Two-flop synchroniser for a single level from outside the clock domain
module sds_sync (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic async_in,
   output logic sync_out
);

   logic meta_reg;

   // First stage is read by the second stage only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_reg <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end

endmodule

// File: logic/sds_top.sv
// What this block does
// - Data byte 3 holds the most significant byte.
// - Byte 3 write starts clock, auto-selects target.
// - Wider frames put low byte at lowest address.
// - MSB-first sends byte3 top, receives into frame bottom.
// - LSB-first sends frame bottom, receives into top.
// - LSB-first result MSB lands in byte len.
// - Status bit D0 reads busy while shifting.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps

`include "sds_defines.svh"

module sds_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [13:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire sds_pkg::sds_word_t avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output sds_pkg::sds_word_t avs_readdata,
   output logic avs_waitrequest,
   output logic spi_sclk,
   output logic spi_mosi,
   output logic spi_ss_n,
   input wire logic spi_miso,
   output logic irq
);

   import sds_pkg::*;

   sds_ctrl_s ctrl_reg;
   sds_state_e state_reg;
   sds_word_t word_reg;
   sds_word_t shift_next;
   sds_word_t load_word;
   sds_word_t frame_mask;
   sds_word_t rd_next;
   logic ack_reg;
   logic [11:0] idx;
   logic wr_acc;
   logic rd_acc;
   logic data_hit;
   logic [1:0] byte_sel;
   logic start;
   logic refused;
   logic busy;
   logic [5:0] nbits;
   logic [4:0] lowpos;
   logic [5:0] bit_cnt_reg;
   logic [2:0] div_cnt_reg;
   logic tick;
   logic sclk_reg;
   logic mosi_reg;
   logic auto_ss_reg;
   logic rx_bit_reg;
   logic miso_s;
   logic fall;
   logic last_bit;
   logic done;
   logic [1:0] irq_st_reg;
   logic [1:0] irq_mask_reg;
   logic [1:0] irq_ev;
   logic [1:0] rd_clr;

   // Bit that leaves first for the given order and frame start
   function automatic logic tx_of(input sds_word_t w, input logic lsb, input logic [4:0] lp);
      logic b;
      b = lsb ? w[lp] : w[31];
      return b;
   endfunction

   // Incoming data pin crosses into the clock domain
   sds_sync u_miso_sync (
      .clk(clk),
      .arst_n(arst_n),
      .async_in(spi_miso),
      .sync_out(miso_s)
   );

   // Bus decode; the word index is the byte address over four
   assign idx = avs_address[13:2];
   assign wr_acc = avs_write & ack_reg;
   assign rd_acc = avs_read & ack_reg;
   assign data_hit = (idx >= `SDS_IDX_DATA0) && (idx <= `SDS_IDX_DATA3);
   assign byte_sel = 2'(idx - `SDS_IDX_DATA0);
   assign busy = (state_reg == sds_shift);

   // One wait cycle per access gives time to register read data
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (avs_read | avs_write) & ~ack_reg;
      end
   end

   assign start = wr_acc & avs_byteenable[0] & (idx == `SDS_IDX_DATA3) & ~busy;
   // Writes that would tear a running frame are dropped and flagged
   assign refused = wr_acc & avs_byteenable[0] & busy
                    & (data_hit | (idx == `SDS_IDX_CTRL));

   assign nbits = {ctrl_reg.frame_length_field + 3'd1, 3'b000};
   assign lowpos = 5'(6'd32 - nbits);
   assign frame_mask = 32'hffff_ffff << lowpos;

   assign load_word = {avs_writedata[7:0], word_reg[23:0]};

   // Serial clock divider, running only while a frame is under way
   assign tick = busy && (div_cnt_reg == 3'(`SDS_HALF_CYC - 1));
   assign fall = tick & sclk_reg;
   assign last_bit = (bit_cnt_reg == 6'd1);
   assign done = fall & last_bit;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_reg <= 3'h0;
      end else if (!busy || tick) begin
         div_cnt_reg <= 3'h0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 3'd1;
      end
   end

   // Next word after one falling edge, bits outside the frame kept except on the LSB-first last bit
   always_comb begin
      shift_next = word_reg;
      if (ctrl_reg.low_bit_first_order) begin
         shift_next = ({rx_bit_reg, word_reg[31:1]} & frame_mask) | (word_reg & ~frame_mask);
         if (last_bit) begin
            shift_next = shift_next >> lowpos;
         end
      end else begin
         shift_next = ((word_reg << 1) & frame_mask) | (word_reg & ~frame_mask);
         shift_next[lowpos] = rx_bit_reg;
      end
   end

   // Frame sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= sds_idle;
         bit_cnt_reg <= 6'h00;
      end else begin
         unique case (state_reg)
            sds_idle: begin
               if (start) begin
                  state_reg <= sds_shift;
                  bit_cnt_reg <= nbits;
               end
            end
            sds_shift: begin
               if (done) begin
                  state_reg <= sds_idle;
               end
               if (fall) begin
                  bit_cnt_reg <= bit_cnt_reg - 6'd1;
               end
            end
         endcase
      end
   end

   // Data word: host byte writes when idle, shifting while busy
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         word_reg <= 32'h0000_0000;
      end else if (busy) begin
         if (fall) begin
            word_reg <= shift_next;
         end
      end else if (wr_acc && avs_byteenable[0] && data_hit) begin
         word_reg[8 * byte_sel +: 8] <= avs_writedata[7:0];
      end
   end

   // Serial clock idles low; data changes on the falling edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sclk_reg <= 1'b0;
      end else if (done || !busy) begin
         sclk_reg <= 1'b0;
      end else if (tick) begin
         sclk_reg <= ~sclk_reg;
      end
   end

   // Sample the target on the rising edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_bit_reg <= 1'b0;
      end else if (tick && !sclk_reg) begin
         rx_bit_reg <= miso_s;
      end
   end

   // Outgoing bit, presented half a period before each rising edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mosi_reg <= 1'b0;
      end else if (start) begin
         mosi_reg <= tx_of(load_word, ctrl_reg.low_bit_first_order, lowpos);
      end else if (fall && !last_bit) begin
         mosi_reg <= tx_of(shift_next, ctrl_reg.low_bit_first_order, lowpos);
      end
   end

   // Automatic target select follows the frame
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         auto_ss_reg <= 1'b0;
      end else if (start) begin
         auto_ss_reg <= ~ctrl_reg.manual_select_control;
      end else if (done) begin
         auto_ss_reg <= 1'b0;
      end
   end

   assign spi_sclk = sclk_reg;
   assign spi_mosi = mosi_reg;
   // Manual mode lets software hold the select across several frames
   assign spi_ss_n = ~(auto_ss_reg | (ctrl_reg.manual_select_control & ctrl_reg.man_level));

   // Control register, frozen while a frame runs
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg <= `SDS_CTRL_RESET;
      end else if (wr_acc && avs_byteenable[0] && idx == `SDS_IDX_CTRL && !busy) begin
         ctrl_reg <= avs_writedata[4:0];
      end
   end

   // Interrupt events; a set in the clearing cycle survives
   always_comb begin
      irq_ev = 2'b00;
      irq_ev[`SDS_IRQ_DONE] = done;
      irq_ev[`SDS_IRQ_REFUSED] = refused;
   end

   // Only bits the host actually saw are cleared by the read
   assign rd_clr = (rd_acc && idx == `SDS_IDX_IRQ_ST) ? avs_readdata[1:0] : 2'b00;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_st_reg <= `SDS_IRQ_RESET;
      end else begin
         irq_st_reg <= (irq_st_reg & ~rd_clr) | irq_ev;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_mask_reg <= `SDS_IRQ_RESET;
      end else if (wr_acc && avs_byteenable[0] && idx == `SDS_IDX_IRQ_MASK) begin
         irq_mask_reg <= avs_writedata[1:0];
      end
   end

   assign irq = |(irq_st_reg & irq_mask_reg);

   // Read mux; unmapped indices read as zero
   always_comb begin
      rd_next = 32'h0000_0000;
      if (data_hit) begin
         rd_next[7:0] = word_reg[8 * byte_sel +: 8];
      end else if (idx == `SDS_IDX_CTRL) begin
         rd_next[4:0] = ctrl_reg;
      end else if (idx == `SDS_IDX_STAT) begin
         rd_next[`SDS_STAT_BUSY] = busy;
      end else if (idx == `SDS_IDX_IRQ_ST) begin
         rd_next[1:0] = irq_st_reg;
      end else if (idx == `SDS_IDX_IRQ_MASK) begin
         rd_next[1:0] = irq_mask_reg;
      end
   end

   // Read data captured in the wait cycle and held until the next read
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && !ack_reg) begin
         avs_readdata <= rd_next;
      end
   end

endmodule

// File: bench/sds_top_asserts.sv
`timescale 1ns/1ps

// Port checker for the shift block
module sds_top_asserts (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire sds_pkg::sds_word_t avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_ss_n
);
   import sds_pkg::*;
   logic [5:0] rise_cnt;
   logic sclk_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   // Rising serial edges inside one select window
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rise_cnt <= 6'h00;
         sclk_q <= 1'b0;
      end else begin
         sclk_q <= spi_sclk;
         if (spi_ss_n) rise_cnt <= 6'h00;
         else if (spi_sclk && !sclk_q) rise_cnt <= rise_cnt + 6'h01;
      end
   end
   a_req_one_wait: assert property ((avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest ##1 !avs_waitrequest) else $error("wait state not one cycle");
   a_read_upper_zero: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
   a_sclk_high_four: assert property ($rose(spi_sclk) |-> spi_sclk[*4] ##1 !spi_sclk)
      else $error("sclk high phase wrong");
   a_sclk_low_four: assert property ($fell(spi_sclk) |-> !spi_sclk[*4])
      else $error("sclk low phase short");
   a_mosi_hold_high: assert property (spi_sclk |-> $stable(spi_mosi))
      else $error("mosi moved while sclk high");
   a_ss_lead_time: assert property ($fell(spi_ss_n) |-> !spi_sclk[*4] ##1 spi_sclk)
      else $error("first sclk rise misplaced");
   a_frame_bit_count: assert property ($rose(spi_ss_n)
      |-> rise_cnt inside {6'h08, 6'h10, 6'h18, 6'h20}) else $error("frame bit count wrong");
   a_ss_sclk_idle: assert property (spi_ss_n |-> !spi_sclk)
      else $error("sclk toggles without select");
endmodule

bind sds_top sds_top_asserts sds_top_asserts_inst (.clk(clk), .arst_n(arst_n),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
   .spi_ss_n(spi_ss_n));

// File: bench/sds_tgt.sv
`timescale 1ns/1ps

// Mode 0 serial target: replies with tx_word, records what it receives
module sds_tgt (
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   input wire logic spi_ss_n,
   input wire sds_pkg::sds_word_t tx_word,
   output logic spi_miso,
   output sds_pkg::sds_word_t rx_word
);
   import sds_pkg::*;
   sds_word_t sh;
   initial spi_miso = 1'b0;
   // First bit must be out before the first rising edge
   always @(negedge spi_ss_n) begin
      sh = tx_word;
      rx_word = 32'h0000_0000;
      spi_miso = sh[31];
   end
   // Sample on rise
   always @(posedge spi_sclk) if (!spi_ss_n) rx_word = {rx_word[30:0], spi_mosi};
   // Next bit on fall
   always @(negedge spi_sclk) begin
      if (!spi_ss_n) begin
         sh = {sh[30:0], 1'b0};
         spi_miso = sh[31];
      end
   end
   // Released line shows the inverse so a stale bit cannot pass
   always @(posedge spi_ss_n) spi_miso = ~spi_miso;
endmodule

// File: bench/sds_top_tb.sv
`timescale 1ns/1ps

`include "sds_defines.svh"

module sds_top_tb;
   import sds_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [13:0] adr = 14'h0000;
   sds_word_t wd = 32'h0000_0000;
   sds_word_t tx = 32'h0000_0000;
   sds_word_t rdata, rx;
   logic wait_r, sclk, mosi, ss_n, miso, irq;
   logic [7:0] q;
   int error_cnt = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   sds_top sds_top_inst (.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata),
      .avs_waitrequest(wait_r), .spi_sclk(sclk), .spi_mosi(mosi), .spi_ss_n(ss_n),
      .spi_miso(miso), .irq(irq));
   sds_tgt sds_tgt_inst (.spi_sclk(sclk), .spi_mosi(mosi), .spi_ss_n(ss_n),
      .tx_word(tx), .spi_miso(miso), .rx_word(rx));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // One Avalon access; request held until waitrequest is seen low
   task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] d);
      int t;
      t = 0;
      @(posedge clk);
      adr <= {idx, 2'b00};
      wr <= w;
      rd <= !w;
      wd <= {24'h00_0000, d};
      @(negedge clk);
      while (wait_r !== 1'b0 && t < 20) begin
         @(negedge clk);
         t++;
      end
      if (t == 20) chk(1'b0, 1'b1);
      // Read data is taken at the edge where waitrequest is sampled low
      @(posedge clk);
      q = rdata[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   // Full frame: load, start, lock check, wait, result and wire checks
   task automatic frame(input logic lsb, input logic [1:0] len, input sds_word_t w);
      int n;
      int t;
      sds_word_t txv, res, got_d, exp_d, got_r, exp_r;
      n = 8 * (len + 1);
      txv = ~w ^ 32'h5a5a_0f0f;
      tx <= txv;
      bus(1'b1, `SDS_IDX_IRQ_MASK, {7'h00, !lsb});
      bus(1'b1, `SDS_IDX_CTRL, {4'h0, len, lsb, 1'b0});
      for (int i = 0; i < 4; i++) bus(1'b1, 12'(`SDS_IDX_DATA0 + i), w[8*i +: 8]);
      bus(1'b0, `SDS_IDX_STAT, 8'h00);
      chk(q, 1'b1);
      bus(1'b1, `SDS_IDX_CTRL, {4'h0, ~len, ~lsb, 1'b0});
      t = 0;
      do begin
         bus(1'b0, `SDS_IDX_STAT, 8'h00);
         t++;
      end while (q[0] !== 1'b0 && t < 200);
      @(negedge clk);
      chk({ss_n, irq}, {1'b1, !lsb});
      bus(1'b0, `SDS_IDX_IRQ_ST, 8'h00);
      chk(q, 8'h03);
      @(negedge clk);
      chk(irq, 1'b0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, 12'(`SDS_IDX_DATA0 + i), 8'h00);
         res[8*i +: 8] = q;
      end
      got_d = 32'h0000_0000;
      exp_d = 32'h0000_0000;
      got_r = 32'h0000_0000;
      exp_r = 32'h0000_0000;
      for (int j = 0; j < n; j++) begin
         got_d[j] = lsb ? res[j] : res[32-n+j];
         exp_d[j] = lsb ? txv[31-j] : txv[32-n+j];
         got_r[j] = rx[j];
         exp_r[j] = lsb ? w[31-j] : w[32-n+j];
      end
      chk(got_d, exp_d);
      chk(got_r, exp_r);
   endtask
   initial begin
      #1000000;
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      bus(1'b1, 12'hc90, 8'hff);
      bus(1'b0, 12'hc90, 8'h00);
      chk(q, 1'b0);
      // Every length in both bit orders
      for (int c = 0; c < 8; c++) frame(c[0], c[2:1], 32'h9e37_79b9 * (c + 1));
      finish_test();
   end
endmodule
